/* File: verilog/edbc_defines.svh */
// register map, field positions and limits of the dma bus config block
`ifndef EDBC_DEFINES_SVH
`define EDBC_DEFINES_SVH
`define EDBC_ADDR_W 4
`define EDBC_OFS_CONFIG 4'h0
`define EDBC_OFS_BURST 4'h1
`define EDBC_OFS_STATUS 4'h2
`define EDBC_OFS_ENABLE 4'h3
`define EDBC_OFS_STATE 4'h4
`define EDBC_CFG_WEIGHT_LSB 0
`define EDBC_CFG_RATIO_LSB 2
`define EDBC_CFG_TXFAV 4
`define EDBC_CFG_STRICT 5
`define EDBC_CFG_ALIGN 6
`define EDBC_CFG_FIXED 7
`define EDBC_CFG_MIXED 8
`define EDBC_CFG_EXTDESC 9
`define EDBC_CFG_SKIP_LSB 10
`define EDBC_CFG_JUMBO 15
`define EDBC_CFG_RESET 32'h0000_0000
`define EDBC_BURST_RESET 32'h0000_0101
`define EDBC_NEV 14
`define EDBC_NORMAL_MASK 14'h0281
`define EDBC_NORMAL_BIT 14
`define EDBC_ABNORMAL_BIT 15
`define EDBC_RX_LIMIT 14'h0800
`define EDBC_RX_LIMIT_JUMBO 14'h2800
`define EDBC_DESC_WORDS 6'h04
`define EDBC_DESC_WORDS_EXT 6'h08
`endif

/* File: verilog/edbc_pkg.sv */
// types of the dma bus config block
package edbc_pkg;
   typedef enum logic [3:0] {
      EV_RECEIVE, EV_EARLY_RX, EV_BUS_ERR, EV_EARLY_TX, EV_RX_WDOG,
      EV_RX_STOP, EV_RX_NOBUF, EV_TRANSMIT, EV_TX_UFLOW, EV_TX_STOP,
      EV_RX_OFLOW, EV_TX_JABBER, EV_TX_NOBUF, EV_SPARE
   } edbc_event_t;
   typedef struct packed {
      logic jumbo;
      logic [4:0] desc_skip_words;
      logic extended_desc_layout_option;
      logic variable_burst_option;
      logic fixed_length_burst_option;
      logic burst_align_option;
      logic strict_arbitration_option;
      logic tx_favoured_option;
      logic [1:0] ratio;
      logic [1:0] channel_weight_select;
   } edbc_cfg_t;
   typedef struct packed {
      logic req;
      logic first;
      logic [31:0] addr;
      logic [15:0] remain;
   } edbc_chreq_t;
   typedef enum logic [1:0] { CH_RUN, CH_SUSP, CH_STOP } edbc_chst_t;
endpackage : edbc_pkg

/* File: verilog/edbc_top.sv */
// dma bus arbiter, burst sizer, descriptor stepping and event flags
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "edbc_defines.svh"
module edbc_top (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [`EDBC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire edbc_pkg::edbc_chreq_t i_rx_req,
   input wire edbc_pkg::edbc_chreq_t i_tx_req,
   input wire logic i_bus_done,
   input wire logic i_bus_error,
   input wire logic i_ring_mode,
   input wire logic [31:0] i_desc_addr,
   input wire logic [31:0] i_next_ptr,
   input wire logic i_desc_last,
   input wire logic i_desc_step,
   input wire logic i_rx_desc_host_owned,
   input wire logic i_tx_desc_host_owned,
   input wire logic i_rx_poll_demand,
   input wire logic i_tx_poll_demand,
   input wire logic i_rx_first_buf_filled,
   input wire logic i_rx_byte,
   input wire logic i_rx_frame_end,
   input wire logic i_rx_status_written,
   input wire logic i_rx_overflow,
   input wire logic i_tx_byte,
   input wire logic i_tx_frame_start,
   input wire logic i_tx_frame_in_fifo,
   input wire logic i_tx_status_written,
   input wire logic i_tx_underflow,
   output logic o_grant_rx,
   output logic o_grant_tx,
   output logic [5:0] o_burst_words,
   output logic [31:0] o_next_desc_addr,
   output logic o_dma_enable,
   output logic o_rx_running,
   output logic o_tx_running,
   output logic o_extended_desc,
   output logic o_normal_summary,
   output logic o_abnormal_summary_flag
);
   edbc_pkg::edbc_cfg_t cfg_reg, cfg_next;
   logic [11:0] burst_reg, burst_next;
   logic [`EDBC_NEV-1:0] status_reg, status_next, ev_set, clr;
   logic [`EDBC_NEV-1:0] enable_reg, enable_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wait_reg, wait_next;
   logic dma_en_reg, dma_en_next;
   edbc_pkg::edbc_chst_t rxst_reg, rxst_next, txst_reg, txst_next;
   logic [13:0] rxcnt_reg, rxcnt_next, txcnt_reg, txcnt_next;
   logic [13:0] limit;
   logic grx_reg, grx_next, gtx_reg, gtx_next, busy_reg, busy_next;
   logic [2:0] wcnt_reg, wcnt_next;
   logic [5:0] bw_reg, bw_next;
   logic [31:0] nda_reg, nda_next;
   logic nsum_reg, nsum_next, asum_reg, asum_next;
   logic rx_ok, tx_ok, fav_tx, pick_tx;
   logic [2:0] share;
   logic [5:0] maxb, bw;
   logic [31:0] baddr;
   logic [15:0] brem;
   logic bfirst;
   logic [6:0] to_edge;
   logic [5:0] dwords;
   logic rxrun_reg, rxrun_next, txrun_reg, txrun_next;

   // bus slave: one wait cycle per access, reads answer on that edge
   always_comb
   begin
      cfg_next = cfg_reg;
      burst_next = burst_reg;
      enable_next = enable_reg;
      rdata_next = rdata_reg;
      clr = '0;
      wait_next = 1'b1;
      // writes land on the edge that sees waitrequest low, where the
      // master still holds them; earlier would beat the handshake
      if (avs_write && !wait_reg)
      begin
         case (avs_address)
            `EDBC_OFS_CONFIG: cfg_next = avs_writedata[15:0];
            `EDBC_OFS_BURST: burst_next = avs_writedata[11:0];
            `EDBC_OFS_STATUS: clr = avs_writedata[`EDBC_NEV-1:0];
            `EDBC_OFS_ENABLE: enable_next = avs_writedata[`EDBC_NEV-1:0];
            default: ;
         endcase
      end
      else if ((avs_read || avs_write) && wait_reg)
      begin
         wait_next = 1'b0;
         if (avs_read)
         begin
            case (avs_address)
               `EDBC_OFS_CONFIG: rdata_next = {16'h0000, cfg_reg};
               `EDBC_OFS_BURST: rdata_next = {20'h00000, burst_reg};
               `EDBC_OFS_STATUS: rdata_next = {16'h0000, asum_reg, nsum_reg,
                  status_reg};
               `EDBC_OFS_ENABLE: rdata_next = {18'h00000, enable_reg};
               `EDBC_OFS_STATE: rdata_next = {24'h000000, dma_en_reg,
                  1'b0, 2'(txst_reg), 2'(rxst_reg), gtx_reg, grx_reg};
               default: rdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   // channel process states and frame length watch
   always_comb
   begin
      ev_set = '0;
      rxst_next = rxst_reg;
      txst_next = txst_reg;
      dma_en_next = dma_en_reg;
      rxcnt_next = rxcnt_reg;
      txcnt_next = txcnt_reg;
      limit = cfg_reg.jumbo ? `EDBC_RX_LIMIT_JUMBO : `EDBC_RX_LIMIT;
      if (i_bus_error && dma_en_reg)
      begin
         dma_en_next = 1'b0;
         ev_set[edbc_pkg::EV_BUS_ERR] = 1'b1;
      end
      if (i_rx_first_buf_filled)
         ev_set[edbc_pkg::EV_EARLY_RX] = 1'b1;
      if (i_tx_frame_in_fifo)
         ev_set[edbc_pkg::EV_EARLY_TX] = 1'b1;
      // completes wait for descriptor status writeback
      if (i_rx_status_written)
         ev_set[edbc_pkg::EV_RECEIVE] = 1'b1;
      if (i_tx_status_written)
         ev_set[edbc_pkg::EV_TRANSMIT] = 1'b1;
      if (i_rx_overflow)
         ev_set[edbc_pkg::EV_RX_OFLOW] = 1'b1;
      if (i_rx_frame_end)
         rxcnt_next = '0;
      else if (i_rx_byte && rxcnt_reg != 14'h3FFF)
      begin
         rxcnt_next = rxcnt_reg + 14'h0001;
         if (rxcnt_reg == limit)
            ev_set[edbc_pkg::EV_RX_WDOG] = 1'b1;
      end
      if (i_tx_frame_start)
         txcnt_next = '0;
      else if (i_tx_byte && txst_reg == edbc_pkg::CH_RUN)
      begin
         txcnt_next = txcnt_reg + 14'h0001;
         if (txcnt_reg == limit)
         begin
            ev_set[edbc_pkg::EV_TX_JABBER] = 1'b1;
            ev_set[edbc_pkg::EV_TX_STOP] = 1'b1;
            txst_next = edbc_pkg::CH_STOP;
         end
      end
      case (rxst_reg)
         edbc_pkg::CH_RUN:
            if (i_rx_desc_host_owned)
            begin
               rxst_next = edbc_pkg::CH_SUSP;
               ev_set[edbc_pkg::EV_RX_NOBUF] = 1'b1;
            end
         edbc_pkg::CH_SUSP:
            if (i_rx_poll_demand && !i_rx_desc_host_owned)
               rxst_next = edbc_pkg::CH_RUN;
         edbc_pkg::CH_STOP: ;
         default: rxst_next = edbc_pkg::CH_STOP;
      endcase
      if (txst_reg == edbc_pkg::CH_RUN && txst_next == edbc_pkg::CH_RUN)
      begin
         if (i_tx_underflow)
         begin
            txst_next = edbc_pkg::CH_SUSP;
            ev_set[edbc_pkg::EV_TX_UFLOW] = 1'b1;
         end
         else if (i_tx_desc_host_owned)
         begin
            txst_next = edbc_pkg::CH_SUSP;
            ev_set[edbc_pkg::EV_TX_NOBUF] = 1'b1;
         end
      end
      else if (txst_reg == edbc_pkg::CH_SUSP && i_tx_poll_demand
               && !i_tx_desc_host_owned)
         txst_next = edbc_pkg::CH_RUN;
      // a dead bus, which clears the dma enable, stops both directions
      if (!dma_en_next)
      begin
         if (rxst_reg != edbc_pkg::CH_STOP)
            ev_set[edbc_pkg::EV_RX_STOP] = 1'b1;
         if (txst_reg != edbc_pkg::CH_STOP)
            ev_set[edbc_pkg::EV_TX_STOP] = 1'b1;
         rxst_next = edbc_pkg::CH_STOP;
         txst_next = edbc_pkg::CH_STOP;
      end
      if (!dma_en_reg && dma_en_next)
      begin
         rxst_next = edbc_pkg::CH_RUN;
         txst_next = edbc_pkg::CH_RUN;
      end
      rxrun_next = rxst_next == edbc_pkg::CH_RUN;
      txrun_next = txst_next == edbc_pkg::CH_RUN;
   end

   // sticky flags: set wins over a clear in the same cycle
   always_comb
   begin
      status_next = (status_reg & ~clr) | ev_set;
      nsum_next = |(status_next & enable_reg & `EDBC_NORMAL_MASK);
      asum_next = |(status_next & enable_reg & ~`EDBC_NORMAL_MASK);
   end

   // arbiter: strict favours one side, otherwise weighted round-robin
   always_comb
   begin
      rx_ok = i_rx_req.req && rxst_reg == edbc_pkg::CH_RUN && dma_en_reg;
      tx_ok = i_tx_req.req && txst_reg == edbc_pkg::CH_RUN && dma_en_reg;
      fav_tx = cfg_reg.tx_favoured_option;
      // favoured share: ratio code plus weight code, at least one grant
      share = 3'(cfg_reg.ratio) + 3'(cfg_reg.channel_weight_select)
              + 3'h1;
      if (rx_ok && tx_ok)
      begin
         if (cfg_reg.strict_arbitration_option)
            pick_tx = fav_tx;
         else if (wcnt_reg < share)
            pick_tx = fav_tx;
         else
            pick_tx = !fav_tx;
      end
      else
         pick_tx = tx_ok;
      grx_next = 1'b0;
      gtx_next = 1'b0;
      busy_next = busy_reg;
      wcnt_next = wcnt_reg;
      if (busy_reg)
      begin
         grx_next = grx_reg;
         gtx_next = gtx_reg;
         // a fatal error takes the bus back on the same edge
         if (i_bus_done || !dma_en_next)
         begin
            busy_next = 1'b0;
            grx_next = 1'b0;
            gtx_next = 1'b0;
         end
      end
      else if (rx_ok || tx_ok)
      begin
         busy_next = 1'b1;
         gtx_next = pick_tx;
         grx_next = !pick_tx;
         if (!(rx_ok && tx_ok) || pick_tx != fav_tx)
            wcnt_next = 3'h0;
         else
            wcnt_next = wcnt_reg + 3'h1;
      end
   end

   // burst length for the granted channel
   always_comb
   begin
      maxb = pick_tx ? burst_reg[11:6] : burst_reg[5:0];
      baddr = pick_tx ? i_tx_req.addr : i_rx_req.addr;
      brem = pick_tx ? i_tx_req.remain : i_rx_req.remain;
      bfirst = pick_tx ? i_tx_req.first : i_rx_req.first;
      to_edge = 7'(maxb) - 7'({1'b0, baddr[7:2]} & (7'(maxb) - 7'h01));
      bw = maxb;
      if (cfg_reg.burst_align_option
          && (cfg_reg.fixed_length_burst_option || !bfirst))
         bw = 6'(to_edge);
      if (!cfg_reg.fixed_length_burst_option
          && cfg_reg.variable_burst_option && brem < 16'(bw))
         bw = 6'(brem);
      if (bw == 6'h00)
         bw = 6'h01;
      bw_next = (!busy_reg && (rx_ok || tx_ok)) ? bw : bw_reg;
   end

   // next descriptor: ring skip or chain pointer
   always_comb
   begin
      dwords = cfg_reg.extended_desc_layout_option ? `EDBC_DESC_WORDS_EXT
               : `EDBC_DESC_WORDS;
      nda_next = nda_reg;
      if (i_desc_step)
      begin
         if (!i_ring_mode)
            nda_next = i_next_ptr;
         else if (i_desc_last)
            nda_next = i_desc_addr;
         else
            nda_next = i_desc_addr + {24'h000000, dwords, 2'b00}
               + {25'h0000000, cfg_reg.desc_skip_words, 2'b00};
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         cfg_reg <= 16'(`EDBC_CFG_RESET);
         burst_reg <= 12'(`EDBC_BURST_RESET);
         status_reg <= '0;
         enable_reg <= '0;
         rdata_reg <= 32'h0000_0000;
         wait_reg <= 1'b1;
         dma_en_reg <= 1'b1;
         rxst_reg <= edbc_pkg::CH_RUN;
         txst_reg <= edbc_pkg::CH_RUN;
         rxcnt_reg <= '0;
         txcnt_reg <= '0;
         grx_reg <= 1'b0;
         gtx_reg <= 1'b0;
         busy_reg <= 1'b0;
         wcnt_reg <= 3'h0;
         bw_reg <= 6'h01;
         nda_reg <= 32'h0000_0000;
         nsum_reg <= 1'b0;
         asum_reg <= 1'b0;
         rxrun_reg <= 1'b1;
         txrun_reg <= 1'b1;
      end
      else
      begin
         cfg_reg <= cfg_next;
         burst_reg <= burst_next;
         status_reg <= status_next;
         enable_reg <= enable_next;
         rdata_reg <= rdata_next;
         wait_reg <= wait_next;
         dma_en_reg <= dma_en_next;
         rxst_reg <= rxst_next;
         txst_reg <= txst_next;
         rxcnt_reg <= rxcnt_next;
         txcnt_reg <= txcnt_next;
         grx_reg <= grx_next;
         gtx_reg <= gtx_next;
         busy_reg <= busy_next;
         wcnt_reg <= wcnt_next;
         bw_reg <= bw_next;
         nda_reg <= nda_next;
         nsum_reg <= nsum_next;
         asum_reg <= asum_next;
         rxrun_reg <= rxrun_next;
         txrun_reg <= txrun_next;
      end
   end

   // outputs straight from flip-flops
   always_comb
   begin
      o_avs_readdata = rdata_reg;
      o_avs_waitrequest = wait_reg;
      o_grant_rx = grx_reg;
      o_grant_tx = gtx_reg;
      o_burst_words = bw_reg;
      o_next_desc_addr = nda_reg;
      o_dma_enable = dma_en_reg;
      o_rx_running = rxrun_reg;
      o_tx_running = txrun_reg;
      o_extended_desc = cfg_reg.extended_desc_layout_option;
      o_normal_summary = nsum_reg;
      o_abnormal_summary_flag = asum_reg;
   end
endmodule : edbc_top

/* File: tb/edbc_checker.sv */
// port assertions for the dma bus config block
`timescale 1ns/1ns
`include "edbc_defines.svh"
module edbc_checker (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [`EDBC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic o_avs_waitrequest,
   input wire edbc_pkg::edbc_chreq_t i_rx_req,
   input wire edbc_pkg::edbc_chreq_t i_tx_req,
   input wire logic i_bus_done,
   input wire logic i_bus_error,
   input wire logic o_grant_rx,
   input wire logic o_grant_tx,
   input wire logic [5:0] o_burst_words,
   input wire logic o_dma_enable,
   input wire logic o_rx_running,
   input wire logic o_tx_running
);
   logic [7:0] m_reg, m_next;
   logic acc, gnt, both;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // both channels asking while nobody holds the bus
   assign acc = avs_write && !o_avs_waitrequest;
   assign gnt = o_grant_rx || o_grant_tx;
   assign both = i_rx_req.req && i_tx_req.req && o_rx_running
      && o_tx_running && o_dma_enable && !gnt;
   // mirror of strict, tx favoured and rx max burst, taken on accept
   always_comb
   begin
      m_next = m_reg;
      if (acc && avs_address == 4'h0)
         m_next[7:6] = avs_writedata[5:4];
      if (acc && avs_address == 4'h1)
         m_next[5:0] = avs_writedata[5:0];
   end
   // reset value matches the burst word default of one rx word
   always_ff @(posedge i_ref_clk)
      m_reg <= i_reset ? 8'h01 : m_next;
   sequence s_req;
      (avs_read || avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_ans;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   AST_ACCESS:
      assert property (s_req |=> s_ans) else $error("bad bus answer");
   AST_ONE_GRANT:
      assert property (!(o_grant_rx && o_grant_tx)) else $error("two grants");
   AST_STRICT_RX:
      assert property (both && m_reg[7] && !m_reg[6] |=> o_grant_rx)
      else $error("strict rx lost");
   AST_STRICT_TX:
      assert property (both && m_reg[7] && m_reg[6] |=> o_grant_tx)
      else $error("strict tx lost");
   AST_SERVE:
      assert property (both |=> gnt) else $error("request not served");
   AST_BURST_CAP:
      assert property ($rose(o_grant_rx) |-> o_burst_words != 6'h00
         && o_burst_words <= m_reg[5:0]) else $error("rx burst too long");
   AST_GRANT_HOLD:
      assert property (gnt && !i_bus_done && !i_bus_error |=> $stable(gnt))
      else $error("grant dropped early");
   AST_GRANT_DROP:
      assert property (gnt && i_bus_done |=> !gnt) else $error("grant held");
   AST_BUS_ERR:
      assert property (i_bus_error |=> !o_dma_enable [*3])
      else $error("dma still enabled");
   AST_OFF_IDLE:
      assert property (!o_dma_enable && !gnt |=> !gnt)
      else $error("grant while disabled");
endmodule : edbc_checker
bind edbc_top edbc_checker i_edbc_checker (
   .i_ref_clk(i_ref_clk), .i_reset(i_reset), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_rx_req(i_rx_req), .i_tx_req(i_tx_req), .i_bus_done(i_bus_done),
   .i_bus_error(i_bus_error), .o_grant_rx(o_grant_rx),
   .o_grant_tx(o_grant_tx), .o_burst_words(o_burst_words),
   .o_dma_enable(o_dma_enable), .o_rx_running(o_rx_running),
   .o_tx_running(o_tx_running)
);

/* File: tb/edbc_bus_model.sv */
// system bus model: ends each granted burst, errors only on command
`timescale 1ns/1ns
module edbc_bus_model (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_grant,
   input wire logic i_slow,
   input wire logic i_fail,
   output logic o_done,
   output logic o_error
);
   logic [2:0] cnt_reg, cnt_next;
   logic done_next, err_next;
   // beat count of the burst; slow mode stretches the answer
   always_comb
   begin
      cnt_next = 3'h0;
      done_next = 1'b0;
      err_next = i_grant && i_fail && !o_error;
      if (i_grant && !o_done)
         cnt_next = cnt_reg + 3'h1;
      if (i_grant && !o_done && cnt_reg == (i_slow ? 3'h5 : 3'h1))
         done_next = 1'b1;
   end
   // done is a single pulse; the grant falls the cycle after it
   always_ff @(posedge i_ref_clk)
   begin
      cnt_reg <= i_reset ? 3'h0 : cnt_next;
      o_done <= !i_reset && done_next;
      o_error <= !i_reset && err_next;
   end
endmodule : edbc_bus_model

/* File: tb/tb_edbc_top.sv */
// testbench of the dma bus config block
`timescale 1ns/1ns
module tb_edbc_top;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ring = 1'b0;
   logic slow = 1'b0, fail = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, r, rdata, nxt;
   logic [1:0] own = 2'h0;
   logic [12:0] p = 13'h0;
   logic wt, done, berr, grx, gtx, dmae, rxr, txr, ext, nsum, asum;
   logic [5:0] bw;
   edbc_pkg::edbc_chreq_t rxq = '{1'b0, 1'b1, 32'h0, 16'h0040};
   edbc_pkg::edbc_chreq_t txq = '{1'b0, 1'b1, 32'h0, 16'h0040};
   int n_errors = 0, checks_done = 0;
   int evb[4] = '{1, 3, 10, 8};
   always #5 clk = ~clk;
   edbc_top i_edbc_top (
      .i_ref_clk(clk), .i_reset(rst), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wt), .i_rx_req(rxq), .i_tx_req(txq),
      .i_bus_done(done), .i_bus_error(berr), .i_ring_mode(ring),
      .i_desc_addr(32'h0000_0100), .i_next_ptr(32'h0000_4000),
      .i_desc_last(1'b0), .i_desc_step(p[10]), .i_rx_desc_host_owned(own[0]),
      .i_tx_desc_host_owned(own[1]), .i_rx_poll_demand(p[8]),
      .i_tx_poll_demand(p[9]), .i_rx_first_buf_filled(p[0]),
      .i_rx_byte(p[11]), .i_rx_frame_end(p[4]), .i_rx_status_written(p[5]),
      .i_rx_overflow(p[2]), .i_tx_byte(p[12]), .i_tx_frame_start(p[6]),
      .i_tx_frame_in_fifo(p[1]), .i_tx_status_written(p[7]),
      .i_tx_underflow(p[3]), .o_grant_rx(grx), .o_grant_tx(gtx),
      .o_burst_words(bw), .o_next_desc_addr(nxt), .o_dma_enable(dmae),
      .o_rx_running(rxr), .o_tx_running(txr), .o_extended_desc(ext),
      .o_normal_summary(nsum), .o_abnormal_summary_flag(asum)
   );
   edbc_bus_model i_edbc_bus_model (
      .i_ref_clk(clk), .i_reset(rst), .i_grant(grx | gtx), .i_slow(slow),
      .i_fail(fail), .o_done(done), .o_error(berr)
   );
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   // one avalon access; always entered just after a rising edge
   task automatic acc(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wt !== 1'b0)
         @(posedge clk);
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask : acc
   task automatic st(input int b, input logic e);
      acc(1'b0, 4'h2, 32'h0);
      chk(r[b], e);
   endtask : st
   // strobe an input for n cycles, then let status and summaries land
   task automatic pulse(input int i, input int n);
      p[i] <= 1'b1;
      repeat (n) @(posedge clk);
      p[i] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse
   task automatic lim(input int i, input int b, input int n);
      pulse(i, n);
      st(b, 1'b0);
      pulse(i, 1);
      st(b, 1'b1);
   endtask : lim
   // withdraw requests and let any burst already granted finish
   task automatic idle();
      rxq.req <= 1'b0;
      txq.req <= 1'b0;
      repeat (2) @(posedge clk);
      while ((grx | gtx) !== 1'b0)
         @(posedge clk);
   endtask : idle
   task automatic arb(input logic [31:0] c, input int lo, input int hi);
      int nr;
      nr = 0;
      acc(1'b1, 4'h0, c);
      rxq.req <= 1'b1;
      txq.req <= 1'b1;
      repeat (8)
      begin
         while ((grx | gtx) !== 1'b1)
            @(posedge clk);
         nr += grx;
         while ((grx | gtx) !== 1'b0)
            @(posedge clk);
      end
      chk(nr >= lo && nr <= hi, 1'b1);
      idle();
   endtask : arb
   task automatic burst(input logic [5:0] e);
      while ((grx | gtx) !== 1'b1)
         @(posedge clk);
      chk(bw, e);
      idle();
   endtask : burst
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      acc(1'b0, 4'h1, 32'h0);
      chk(r, 32'h0000_0101);
      acc(1'b1, 4'hF, 32'hFFFF_FFFF);
      acc(1'b0, 4'hF, 32'h0);
      chk({r[1:0], dmae, ext}, 4'h2);
      arb(32'h20, 8, 8);
      arb(32'h30, 0, 0);
      arb(32'h2C, 8, 8);
      slow <= 1'b1;
      arb(32'h03, 4, 8);
      // every ratio code, rx favoured then swapped
      for (int k = 0; k < 4; k++)
      begin
         arb(k << 2, 4, 8);
         arb((k << 2) | 32'h10, 0, 4);
      end
      acc(1'b1, 4'h1, 32'h0000_0088);
      acc(1'b1, 4'h0, 32'h0000_0080);
      rxq.req <= 1'b1;
      burst(6'h08);
      txq.req <= 1'b1;
      burst(6'h02);
      // rx start at word 6: two words to the eight word edge
      rxq.addr <= 32'h0000_0018;
      acc(1'b1, 4'h0, 32'h0000_00C0);
      rxq.req <= 1'b1;
      burst(6'h02);
      acc(1'b1, 4'h0, 32'h0000_0040);
      rxq.req <= 1'b1;
      burst(6'h08);
      rxq.first <= 1'b0;
      rxq.req <= 1'b1;
      burst(6'h02);
      rxq.remain <= 16'h0003;
      acc(1'b1, 4'h0, 32'h0000_0100);
      rxq.req <= 1'b1;
      burst(6'h03);
      ring <= 1'b1;
      acc(1'b1, 4'h0, 32'h0000_0800);
      pulse(10, 1);
      chk(nxt, 32'h0000_0118);
      acc(1'b1, 4'h0, 32'h0000_0A00);
      pulse(10, 1);
      chk(nxt, 32'h0000_0128);
      chk(ext, 1'b1);
      ring <= 1'b0;
      pulse(10, 1);
      chk(nxt, 32'h0000_4000);
      // host-owned descriptor parks a direction until polled
      for (int i = 0; i < 2; i++)
      begin
         own[i] <= 1'b1;
         rxq.req <= 1'b1;
         txq.req <= 1'b1;
         repeat (4) @(posedge clk);
         st(i ? 12 : 6, 1'b1);
         own[i] <= 1'b0;
         repeat (3) @(posedge clk);
         chk(i ? txr : rxr, 1'b0);
         pulse(8 + i, 1);
         chk(i ? txr : rxr, 1'b1);
         idle();
      end
      acc(1'b1, 4'h3, 32'h0000_3FFF);
      acc(1'b1, 4'h2, 32'h0000_FFFF);
      for (int j = 0; j < 4; j++)
      begin
         pulse(j, 1);
         chk(asum, 1'b1);
         st(evb[j], 1'b1);
         acc(1'b1, 4'h2, 32'h1 << evb[j]);
         st(evb[j], 1'b0);
      end
      chk({asum, txr}, 2'h0);
      pulse(9, 1);
      pulse(4, 1);
      st(0, 1'b0);
      pulse(5, 1);
      st(0, 1'b1);
      chk(nsum, 1'b1);
      lim(11, 4, 2048);
      pulse(4, 1);
      pulse(6, 1);
      lim(12, 11, 2048);
      chk(txr, 1'b0);
      st(9, 1'b1);
      acc(1'b1, 4'h2, 32'h0000_0010);
      acc(1'b1, 4'h0, 32'h0000_8000);
      lim(11, 4, 10240);
      // fatal error in mid-burst; only reset recovers
      rxq.req <= 1'b1;
      while (grx !== 1'b1)
         @(posedge clk);
      fail <= 1'b1;
      @(posedge clk);
      fail <= 1'b0;
      repeat (8) @(posedge clk);
      st(2, 1'b1);
      chk({dmae, grx}, 2'h0);
      st(5, 1'b1);
      // reset is the only way back from a bus error
      rxq.req <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({dmae, rxr, txr, wt, grx, asum}, 6'h3C);
      acc(1'b0, 4'h2, 32'h0);
      chk(r, 32'h0000_0000);
      print_verdict();
   end
   // hang guard, well beyond the longest sequence
   initial
   begin
      #600000;
      n_errors++;
      print_verdict();
   end
endmodule : tb_edbc_top
